// >>> hmc_regs.sv
`timescale 1ns/1ps
module hmc_regs #(
    parameter int unsigned PULSE_LEN = hmc_pkg::PULSE_CYCLES
) (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Serial register port.
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // Event sources.
    input  wire logic       ext_int_n,
    input  wire logic       board_temp_input_n,
    input  wire logic       intrusion_input,
    input  wire logic       fan_one_input,
    input  wire logic       fan_two_input,
    input  wire logic [6:0] voltage_limit_hit,
    input  wire logic [1:0] fan_limit_hit,
    input  wire logic       conversion_done,
    input  wire logic [1:0] temp_above_limit,
    input  wire logic [1:0] temp_below_hyst,
    input  wire logic [3:0] temp_low_bits,
    // Pins driven by the block.
    output logic            general_output_pin_oe_n,
    output logic            int_out,
    output logic            int_oe_n,
    output logic            shared_pin_oe_n,
    output logic            intrusion_clear,
    // Controls to the measurement logic.
    output logic            monitor_run,
    output logic            fan_monitor_run,
    output logic            temp_fine_res,
    output logic [1:0]      fan_one_prescale,
    output logic [1:0]      fan_two_prescale,
    output logic            fan_one_input_mode,
    output logic            fan_two_input_mode
);
    import hmc_pkg::*;

    // Pulse length in cycles at the counter width.
    localparam logic [CNT_W-1:0] PULSE = CNT_W'(PULSE_LEN);

    hmc_state_type q;   // Registered state.
    hmc_state_type d;   // Next state.

    // Bus line events, seen against last cycle's sample.
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       load_rd;    // A read byte is fetched this cycle.
    logic [7:0] rd_data;    // Byte at the pointer.
    logic [7:0] set1;       // Status-1 events this cycle.
    logic [7:0] set2;       // Status-2 events this cycle.
    logic       pending;    // Some unmasked status bit is set.
    logic       fan_lvl_2;
    logic       fan_lvl_1;

    // Open-drain data line only ever pulls low.
    assign sda_out = 1'b0;

    // Read multiplexer; the resolution register shows live temperature
    // bits above its stored controls and the shared pin level at bit 0.
    always_comb begin
        case (q.ptr)
            ADDR_CFG: rd_data = q.cfg;
            ADDR_ST1: rd_data = q.st1;
            ADDR_ST2: rd_data = q.st2;
            ADDR_M1:  rd_data = q.m1;
            ADDR_M2:  rd_data = q.m2;
            ADDR_PIN: rd_data = q.pin;
            ADDR_RES: begin
                rd_data = {q.res[RES_FINE] ? temp_low_bits :
                           {temp_low_bits[3], 3'h0},
                           q.res[3:1], q.sh_oe_n};
            end
            default:  rd_data = 8'h00;
        endcase
    end

    // Event collection. Monitoring results only count while monitoring
    // runs; the pin events count unless status is frozen.
    always_comb begin
        fan_lvl_2 = (fan_two_input == !q.pin[PIN_F2_DIV]);
        fan_lvl_1 = (fan_one_input == !q.pin[PIN_F1_DIV]);
        set1 = 8'h00;
        set2 = 8'h00;
        set1[ST1_EXT] = !ext_int_n;
        set1[6:0] = q.run ? voltage_limit_hit : 7'h00;
        set2[ST2_INTR] = intrusion_input;
        set2[ST2_BTI] = !board_temp_input_n;
        if (q.cfg[CFG_START]) begin
            set2[ST2_FAN2] = q.pin[PIN_F2_MODE] ? fan_lvl_2
                                                : fan_limit_hit[1];
            set2[ST2_FAN1] = q.pin[PIN_F1_MODE] ? fan_lvl_1
                                                : fan_limit_hit[0];
        end
        // Temperature: index 0 is the hot limit, 1 the overtemp limit.
        for (int t = 0; t < 2; t++) begin
            logic one_shot, hit;
            hit = 1'b0;
            one_shot = t == 0 ? q.m2[M2_HOT_MODE] : q.m2[M2_OS_MODE];
            if (one_shot) begin
                hit = conversion_done && temp_above_limit[t]
                      && !q.exc[t];
            end else begin
                hit = conversion_done && !temp_below_hyst[t]
                      && (temp_above_limit[t] || q.exc[t]);
            end
            if (t == 0) begin
                set2[ST2_HOT] = q.run && hit;
            end else begin
                set2[ST2_OS] = q.run && hit;
            end
        end
        if (q.cfg[CFG_FREEZE]) begin
            set1 = 8'h00;
            set2 = 8'h00;
        end
    end

    // Interrupt request from unmasked status bits.
    assign pending = |(q.st1 & ~q.m1) || |(q.st2[5:0] & ~q.m2[5:0]);

    assign scl_rise  = scl && !q.scl;
    assign scl_fall  = !scl && q.scl;
    assign bus_start = scl && q.scl && q.sda && !sda_in;
    assign bus_stop  = scl && q.scl && !q.sda && sda_in;

    // Next-state logic: serial slave, register writes, counters, pins.
    always_comb begin
        d = q;
        load_rd = 1'b0;
        d.scl = scl;
        d.sda = sda_in;

        // Pulse counters run down; the clear counter's end clears its bit, the reset counter's end only in reset-only pin mode.
        if (q.clr_cnt != '0) begin
            d.clr_cnt = q.clr_cnt - CNT_W'(1);
            if (q.clr_cnt == CNT_W'(1)) begin
                d.cfg[CFG_ICLR] = 1'b0;
            end
        end
        if (q.rst_cnt != '0) begin
            d.rst_cnt = q.rst_cnt - CNT_W'(1);
            if (q.rst_cnt == CNT_W'(1) && q.pin[PIN_RST_EN]
                && !q.pin[PIN_OS_EN]) begin
                d.cfg[CFG_RST] = 1'b0;
            end
        end

        // Serial slave. Data is taken on the rising clock edge and the
        // line is changed only on the falling edge, as the bus expects.
        if (bus_start) begin
            d.bus = BUS_ADDR_IN;
            d.bits = 4'h0;
            d.sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            d.bus = BUS_IDLE;
            d.sda_oe_n = 1'b1;
        end else begin
            case (q.bus)
                BUS_IDLE: begin
                    d.sda_oe_n = 1'b1;
                end
                BUS_ADDR_IN, BUS_WR: begin
                    if (scl_rise) begin
                        d.shift = {q.shift[6:0], sda_in};
                        d.bits = q.bits + 4'h1;
                    end else if (scl_fall && q.bits == 4'h8) begin
                        d.bits = 4'h0;
                        if (q.bus == BUS_WR) begin
                            d.bus = BUS_WR_ACK;
                            d.sda_oe_n = 1'b0;
                            if (q.first) begin
                                d.ptr = q.shift;
                                d.first = 1'b0;
                            end else begin
                                d.ptr = q.ptr + 8'h01;
                                case (q.ptr)
                                    ADDR_CFG: begin
                                        d.cfg = q.shift;
                                        d.cfg[CFG_INIT] = 1'b0;
                                        if (q.shift[CFG_ICLR]) begin
                                            d.clr_cnt = PULSE;
                                        end
                                        if (q.shift[CFG_RST]
                                            && q.rst_cnt <= CNT_W'(1)) begin
                                            d.rst_cnt = PULSE;
                                        end
                                        // Initialisation reloads the
                                        // writable registers.
                                        if (q.shift[CFG_INIT]) begin
                                            d.cfg = RST_CFG;
                                            d.m1 = 8'h00;
                                            d.m2 = 8'h00;
                                            d.pin = RST_PIN;
                                            d.res = RST_RES;
                                        end
                                    end
                                    ADDR_M1:  d.m1 = q.shift;
                                    ADDR_M2:  d.m2 = q.shift;
                                    ADDR_PIN: d.pin = q.shift;
                                    ADDR_RES: d.res = q.shift & RES_WMASK;
                                    default:  d.m1 = q.m1;
                                endcase
                            end
                        end else if (q.shift[7:1] == BUS_ADDR) begin
                            d.bus = BUS_ADDR_ACK;
                            d.rw = q.shift[0];
                            d.sda_oe_n = 1'b0;
                        end else begin
                            d.bus = BUS_IDLE;
                        end
                    end
                end
                BUS_ADDR_ACK, BUS_WR_ACK: begin
                    if (scl_fall) begin
                        d.bits = 4'h0;
                        d.sda_oe_n = 1'b1;
                        d.bus = BUS_WR;
                        if (q.bus == BUS_ADDR_ACK) begin
                            d.first = 1'b1;
                            if (q.rw) begin
                                load_rd = 1'b1;
                            end
                        end
                    end
                end
                BUS_RD: begin
                    if (scl_fall) begin
                        if (q.bits == 4'h8) begin
                            d.bus = BUS_RD_ACK;
                            d.sda_oe_n = 1'b1;
                        end else begin
                            d.shift = {q.shift[6:0], 1'b0};
                            d.sda_oe_n = q.shift[6];
                            d.bits = q.bits + 4'h1;
                        end
                    end
                end
                BUS_RD_ACK: begin
                    if (scl_rise) begin
                        d.ack = !sda_in;
                    end else if (scl_fall) begin
                        if (q.ack) begin
                            load_rd = 1'b1;
                        end else begin
                            d.bus = BUS_IDLE;
                        end
                    end
                end
                default: begin
                    d.bus = BUS_IDLE;
                    d.sda_oe_n = 1'b1;
                end
            endcase
        end

        // Fetch a read byte and drive its first bit; the pointer steps on.
        if (load_rd) begin
            d.bus = BUS_RD;
            d.shift = rd_data;
            d.sda_oe_n = rd_data[7];
            d.bits = 4'h1;
            d.ptr = q.ptr + 8'h01;
        end

        // Status: a read clears, a same-cycle event still sets.
        d.st1 = ((load_rd && q.ptr == ADDR_ST1) ? 8'h00 : q.st1) | set1;
        d.st2 = ((load_rd && q.ptr == ADDR_ST2) ? 8'h00 : q.st2) | set2;

        // Excursion state follows the comparators at each conversion while monitoring runs.
        if (q.run && conversion_done) begin
            for (int t = 0; t < 2; t++) begin
                if (temp_above_limit[t]) begin
                    d.exc[t] = 1'b1;
                end else if (temp_below_hyst[t]) begin
                    d.exc[t] = 1'b0;
                end
            end
        end

        // Pin and control outputs, all registered.
        d.run = q.cfg[CFG_START] && !q.cfg[CFG_FREEZE];
        d.gpo_oe_n = !q.cfg[CFG_GPO];
        d.int_oe_n = !q.cfg[CFG_INTEN];
        d.int_out = (pending && !q.cfg[CFG_FREEZE])
                    == q.cfg[CFG_POL];
        if (q.pin[PIN_RST_EN]) begin
            d.sh_oe_n = (q.rst_cnt == '0);
        end else if (q.pin[PIN_OS_EN]) begin
            // Pull low when the asserted level is low, or the reverse.
            d.sh_oe_n = q.exc[1] == q.res[RES_OS_POL];
        end else begin
            d.sh_oe_n = 1'b1;
        end
    end

    // One register for the whole state; reset is synchronous.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register.
    assign sda_oe_n                = q.sda_oe_n;
    assign general_output_pin_oe_n = q.gpo_oe_n;
    assign int_out                 = q.int_out;
    assign int_oe_n                = q.int_oe_n;
    assign shared_pin_oe_n         = q.sh_oe_n;
    assign intrusion_clear         = q.cfg[CFG_ICLR];
    assign monitor_run             = q.run;
    assign fan_monitor_run         = q.cfg[CFG_START];
    assign temp_fine_res           = q.res[RES_FINE];
    assign fan_one_prescale        = q.pin[PIN_F1_DIV+1:PIN_F1_DIV];
    assign fan_two_prescale        = q.pin[PIN_F2_DIV+1:PIN_F2_DIV];
    assign fan_one_input_mode      = q.pin[PIN_F1_MODE];
    assign fan_two_input_mode      = q.pin[PIN_F2_MODE];

    // General output follows its control bit.
    gpo_drive_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        q.cfg[CFG_GPO] |=> !general_output_pin_oe_n)
        else $error("general output not pulled low");

    // Intrusion clear ends with its counter.
    clear_self_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (q.clr_cnt == CNT_W'(1) && !(load_rd && 1'b0)
         && q.bus != BUS_WR) |=> !intrusion_clear)
        else $error("intrusion clear did not end");

    // Reset pulse shows low on the pin while it runs.
    pulse_low_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (q.rst_cnt != '0 && q.pin[PIN_RST_EN]) |=> !shared_pin_oe_n)
        else $error("reset pulse not on pin");

    // Reset-only mode clears the request bit at pulse end.
    auto_clear_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (q.rst_cnt == CNT_W'(1) && q.pin[7:6] == 2'b10
         && q.bus != BUS_WR) |=> !q.cfg[CFG_RST])
        else $error("reset bit not cleared");

    // Freeze keeps the interrupt inactive.
    int_quiet_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (q.cfg[CFG_FREEZE] && q.cfg[CFG_POL]) |=> !int_out)
        else $error("interrupt active while frozen");

    // Freeze sets no new status bit.
    status_hold_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        q.cfg[CFG_FREEZE] |=> ((q.st1 & ~$past(q.st1)) == 8'h00
                               && (q.st2 & ~$past(q.st2)) == 8'h00))
        else $error("status changed while frozen");

    // Freeze stops monitoring within two cycles.
    run_stop_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        q.cfg[CFG_FREEZE] [*2] |-> !monitor_run)
        else $error("monitoring ran while frozen");

    // Interrupt pin released while disabled.
    int_en_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        !q.cfg[CFG_INTEN] |=> int_oe_n)
        else $error("interrupt driven while disabled");

    // Masked status leaves the interrupt at its idle level.
    mask_gate_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        ((q.st1 & ~q.m1) == 8'h00 && (q.st2[5:0] & ~q.m2[5:0]) == 6'h00
         && q.cfg[CFG_POL]) |=> !int_out)
        else $error("masked status raised interrupt");

    // Level-mode fan input flags its status bit.
    fan_level_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (q.pin[PIN_F2_MODE] && q.cfg[CFG_START] && !q.cfg[CFG_FREEZE]
         && fan_two_input == !q.pin[PIN_F2_DIV]) |=> q.st2[ST2_FAN2])
        else $error("fan level event lost");

endmodule // hmc_regs

// >>> hmc_pkg.sv
// Contract
// - Configuration bit 6 drives general output low.
// - Bit 5 clears intrusion latch, self-clears after 10ms.
// - Bit 4 emits active-low reset pulse, 10ms minimum.
// - Reset-only pin mode clears bit 4 after pulse.
// - Bit 3 holds interrupt inactive, status frozen.
// - Bit 3 suspends temperature and voltage monitoring.
// - Bit 2 selects interrupt polarity, 1 means high.
// - Interrupt output driven only while bit 1 set.
// - Bit 0 runs monitoring; clear means shutdown.
// - Status-1 flags external interrupt and voltage channels.
// - Status-2 bit 5 flags overtemp, mode mask-2 bit 7.
// - Status-2 bit 0 flags hot limit, mode bit 6.
// - Status-2 bit 4 flags chassis intrusion input high.
// - Status-2 bits 3, 2 flag fan limits.
// - Status-2 bit 1 flags board temperature input event.
// - Mask bit 1 blocks its status from interrupt.
// - Default mode re-asserts each conversion until hysteresis.
// - One-shot mode fires once per excursion, re-arms.
// - Pin bit 7 selects reset output; both zero disables.
// - Pin bits 1, 0 choose fan level mode.
// - Level mode divisor bit picks trigger level.
// - Register 0x06 bits 7:4 return temperature low bits; the code does so only with bit 3 set, else bits 6:4 read 0.
// - Two-bit fan divisor selects prescale 1,2,4,8.
package hmc_pkg;

    // Register offsets on the serial port.
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_ST1 = 8'h01;
    localparam logic [7:0] ADDR_ST2 = 8'h02;
    localparam logic [7:0] ADDR_M1  = 8'h03;
    localparam logic [7:0] ADDR_M2  = 8'h04;
    localparam logic [7:0] ADDR_PIN = 8'h05;
    localparam logic [7:0] ADDR_RES = 8'h06;

    // Reset values and the resolution write mask.
    localparam logic [7:0] RST_CFG  = 8'h08;
    localparam logic [7:0] RST_PIN  = 8'h14;
    localparam logic [7:0] RST_RES  = 8'h01;
    localparam logic [7:0] RES_WMASK = 8'h0E;

    // Configuration field positions.
    localparam int CFG_INIT   = 7;
    localparam int CFG_GPO    = 6;
    localparam int CFG_ICLR   = 5;
    localparam int CFG_RST    = 4;
    localparam int CFG_FREEZE = 3;
    localparam int CFG_POL    = 2;
    localparam int CFG_INTEN  = 1;
    localparam int CFG_START  = 0;

    // Pin setup field positions.
    localparam int PIN_RST_EN  = 7;
    localparam int PIN_OS_EN   = 6;
    localparam int PIN_F2_DIV  = 4;
    localparam int PIN_F1_DIV  = 2;
    localparam int PIN_F2_MODE = 1;
    localparam int PIN_F1_MODE = 0;

    // Overtemp and resolution field positions.
    localparam int RES_FINE   = 3;
    localparam int RES_OS_POL = 1;

    // Status and mask field positions.
    localparam int ST1_EXT     = 7;
    localparam int ST2_OS      = 5;
    localparam int ST2_INTR    = 4;
    localparam int ST2_FAN2    = 3;
    localparam int ST2_FAN1    = 2;
    localparam int ST2_BTI     = 1;
    localparam int ST2_HOT     = 0;
    localparam int M2_OS_MODE  = 7;
    localparam int M2_HOT_MODE = 6;

    // Pulse timing: a least time, so it rounds up to whole cycles.
    localparam int PULSE_MS     = 10;
    localparam int CLK_KHZ      = 100000;
    localparam int PULSE_CYCLES = PULSE_MS * CLK_KHZ;
    localparam int CNT_W        = 20;

    // Serial slave address; the value is arbitrary.
    localparam logic [6:0] BUS_ADDR = 7'h2C;

    // Serial slave sequence.
    typedef enum logic [2:0] {
        BUS_IDLE, BUS_ADDR_IN, BUS_ADDR_ACK, BUS_WR, BUS_WR_ACK,
        BUS_RD, BUS_RD_ACK
    } hmc_bus_state_type;

    // Whole state of the block.
    typedef struct packed {
        hmc_bus_state_type bus;
        logic              scl;
        logic              sda;
        logic [3:0]        bits;
        logic [7:0]        shift;
        logic              rw;
        logic              first;
        logic              ack;
        logic [7:0]        ptr;
        logic [7:0]        cfg;
        logic [7:0]        st1;
        logic [7:0]        st2;
        logic [7:0]        m1;
        logic [7:0]        m2;
        logic [7:0]        pin;
        logic [7:0]        res;
        logic [1:0]        exc;
        logic [CNT_W-1:0]  rst_cnt;
        logic [CNT_W-1:0]  clr_cnt;
        logic              sda_oe_n;
        logic              gpo_oe_n;
        logic              int_out;
        logic              int_oe_n;
        logic              sh_oe_n;
        logic              run;
    } hmc_state_type;

    localparam hmc_state_type RST_STATE = '{
        bus: BUS_IDLE, scl: 1'b1, sda: 1'b1, bits: 4'h0, shift: 8'h00,
        rw: 1'b0, first: 1'b0, ack: 1'b0, ptr: 8'h00, cfg: RST_CFG,
        st1: 8'h00, st2: 8'h00, m1: 8'h00, m2: 8'h00, pin: RST_PIN,
        res: RST_RES, exc: 2'h0, rst_cnt: 20'h00000, clr_cnt: 20'h00000,
        sda_oe_n: 1'b1, gpo_oe_n: 1'b1, int_out: 1'b1, int_oe_n: 1'b1,
        sh_oe_n: 1'b1, run: 1'b0
    };

endpackage

// >>> hmc_host.sv
`timescale 1ns/1ps
// Serial host model; it owns the clock line and releases data as 1.
module hmc_host (
    // Clock and data wire.
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Steps just past an edge so the device never sees a race.
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Start, or a repeated start from a low clock line.
    task automatic start();
        sda_drv = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
        tick(4);
    endtask
    // One byte out and one acknowledge bit; data is sampled late high.
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic ack);
        logic [8:0] s;
        for (int i = 8; i >= 0; i--) begin
            sda_drv = (i == 0) ? last : d[i-1];
            tick(4);
            scl = 1'b1;
            tick(4);
            s[i] = sda_line;
            scl = 1'b0;
            tick(4);
        end
        q = s[8:1];
        ack = !s[0];
    endtask
    // Stop ends every access, which leaves the wire idle high.
    task automatic stop();
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(4);
    endtask
    // Pointer then data; the device acknowledges each byte.
    task automatic wr(input logic [7:0] p, d, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        xfer({hmc_pkg::BUS_ADDR, 1'b0}, 1'b1, q, a0);
        xfer(p, 1'b1, q, a1);
        xfer(d, 1'b1, q, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // Pointer write, then a read ended by a not-acknowledge.
    task automatic rd(input logic [7:0] p, output logic [7:0] q,
                      output logic ok);
        logic a0, a1, a2, n;
        start();
        xfer({hmc_pkg::BUS_ADDR, 1'b0}, 1'b1, q, a0);
        xfer(p, 1'b1, q, a1);
        start();
        xfer({hmc_pkg::BUS_ADDR, 1'b1}, 1'b1, q, a2);
        xfer(8'hFF, 1'b1, q, n);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule // hmc_host

// >>> test_hw_monitor_ctrl_status_regs.sv
`timescale 1ns/1ps
module test_hw_monitor_ctrl_status_regs;
    import hmc_pkg::*;
    localparam int PL = 50; // Short pulse keeps the run brief.
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [18:0] ev = 19'h00000; // Event sources packed in one vector.
    logic [3:0]  tlb = 4'h0;
    logic [31:0] lfsr = 32'd96470;
    logic [7:0]  q;
    logic        ok, scl, sda_drv, sda_oe_n, gpo_n, int_out, int_oe_n;
    logic        sh_n, iclr, run;
    int          errors = 0;
    int          compares = 0;
    int          nlow = 0;
    int          nclr = 0;
    wire         sda_line = sda_drv & sda_oe_n; // Pull-up on the wire.
    always #5 clock = ~clock;
    // Counts the cycles that each timed pulse stays active.
    always @(posedge clock) begin
        if (sh_n === 1'b0) nlow++;
        if (iclr === 1'b1) nclr++;
    end
    hmc_host i_hmc_host (.clock(clock), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));
    hmc_regs #(.PULSE_LEN(PL)) i_hmc_regs (.clock(clock),
        .reset_n(reset_n), .scl(scl), .sda_in(sda_line), .sda_out(),
        .sda_oe_n(sda_oe_n), .ext_int_n(!ev[7]),
        .board_temp_input_n(!ev[8]), .intrusion_input(ev[9]),
        .fan_one_input(ev[12]), .fan_two_input(ev[13]),
        .voltage_limit_hit(ev[6:0]), .fan_limit_hit(ev[11:10]),
        .conversion_done(ev[14]), .temp_above_limit(ev[16:15]),
        .temp_below_hyst(ev[18:17]), .temp_low_bits(tlb),
        .general_output_pin_oe_n(gpo_n), .int_out(int_out),
        .int_oe_n(int_oe_n), .shared_pin_oe_n(sh_n),
        .intrusion_clear(iclr), .monitor_run(run), .fan_monitor_run(),
        .temp_fine_res(), .fan_one_prescale(), .fan_two_prescale(),
        .fan_one_input_mode(), .fan_two_input_mode());
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Status-2 expected from one vector of pin and fan events.
    function automatic logic [7:0] st2_exp(input logic [11:0] v);
        return {3'h0, v[9], v[11:10], v[8], 1'b0};
    endfunction
    task automatic chk(input logic [8:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task automatic give_verdict();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        i_hmc_host.wr(a, d, ok);
        chk(ok, 1, "write refused");
    endtask
    task automatic rr(input logic [7:0] a, e);
        i_hmc_host.rd(a, q, ok);
        chk({ok, q}, {1'b1, e}, "read value");
    endtask
    // One cycle of events, then time for status and interrupt to settle.
    task automatic pulse(input logic [18:0] v);
        ev = v;
        i_hmc_host.tick(1);
        ev = 19'h00000;
        i_hmc_host.tick(3);
    endtask
    // A hang is cut short here.
    initial begin
        repeat (100000) @(posedge clock);
        errors++;
        give_verdict();
    end
    initial begin
        i_hmc_host.tick(2);
        reset_n = 1'b1;
        i_hmc_host.tick(2);
        rr(ADDR_CFG, RST_CFG);
        rr(ADDR_PIN, RST_PIN);
        rr(ADDR_RES, 8'h01);
        rr(8'h07, 8'h00);
        wr(ADDR_CFG, 8'h40);
        chk(gpo_n, 0, "output pin");
        wr(ADDR_CFG, 8'h07);
        chk({int_oe_n, run}, 1, "enable or run");
        // Random events; polarity high so the output equals pending.
        for (int k = 0; k < 6; k++) begin
            lfsr = nxt(lfsr);
            tlb = lfsr[15:12];
            // Fan inputs toggle too; count mode must ignore their level.
            pulse({5'h00, lfsr[13:0]});
            chk(int_out, |lfsr[11:0], "interrupt level");
            rr(ADDR_ST1, lfsr[7:0]);
            rr(ADDR_ST2, st2_exp(lfsr[11:0]));
            chk(int_out, 0, "interrupt kept");
            rr(ADDR_RES, {tlb[3], 7'h01});
        end
        wr(ADDR_RES, 8'h08);
        rr(ADDR_RES, {tlb, 4'h9});
        // Temperature events: repeat until hysteresis, then one-shot.
        pulse(19'h1C000);
        chk(int_out, 1, "temperature interrupt");
        rr(ADDR_ST2, 8'h21);
        pulse(19'h04000);
        rr(ADDR_ST2, 8'h21);
        pulse(19'h64000);
        rr(ADDR_ST2, 8'h00);
        wr(ADDR_M2, 8'hC0);
        for (int k = 0; k < 2; k++) begin
            pulse(19'h1C000);
            rr(ADDR_ST2, k == 0 ? 8'h21 : 8'h00);
        end
        // Overtemp pin shows the excursion; fan two in level mode.
        wr(ADDR_PIN, 8'h46);
        chk(sh_n, 0, "overtemp pin");
        pulse(19'h02000);
        rr(ADDR_ST2, 8'h08);
        wr(ADDR_M1, 8'hFF);
        wr(ADDR_M2, 8'h3F);
        pulse(19'h02FFF);
        chk(int_out, 0, "masked event");
        rr(ADDR_ST1, 8'hFF);
        rr(ADDR_ST2, 8'h1E);
        wr(ADDR_CFG, 8'h0F);
        chk(run, 0, "monitor frozen");
        pulse(19'h0007F);
        rr(ADDR_ST1, 8'h00);
        wr(ADDR_PIN, 8'h94);
        nlow = 0;
        wr(ADDR_CFG, 8'h11);
        i_hmc_host.tick(PL + 20);
        chk(9'(nlow), 9'(PL), "reset pulse length");
        rr(ADDR_CFG, 8'h01);
        nclr = 0;
        wr(ADDR_CFG, 8'h20);
        i_hmc_host.tick(PL + 20);
        chk(9'(nclr), 9'(PL), "clear pulse length");
        rr(ADDR_CFG, 8'h00);
        give_verdict();
    end
endmodule // test_hw_monitor_ctrl_status_regs
